// ---- rtl/pim_pkg.sv ----
package pim_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_PINS = 64;
   localparam int PIN_IDX_W = 6;
   localparam int SEL_W = 8;
   localparam int ROUTE_W = 16;
   localparam int NUM_ROUTE = 9;
   localparam int NUM_OUT = 18;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;

   // ----------------------------------------------------------------
   // Register map (word indices, byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_ROUTE_FIRST = 6'h00;
   localparam logic [IDX_W-1:0] IDX_LOCK = 6'h09;
   localparam logic [IDX_W-1:0] IDX_KEY = 6'h0A;

   // ----------------------------------------------------------------
   // Fields and values
   // ----------------------------------------------------------------
   localparam int HI_LSB = 8;
   localparam int LO_LSB = 0;
   localparam int LOCK_BIT = 11;
   localparam int STRB_LO = 0;
   localparam int STRB_HI = 1;
   localparam logic [ROUTE_W-1:0] ROUTE_RESET = 16'h0000;
   localparam logic [SEL_W-1:0] KEY_FIRST = 8'h55;
   localparam logic [SEL_W-1:0] KEY_SECOND = 8'hAA;
   localparam logic OUT_OF_TABLE_LEVEL = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      UNL_IDLE = 2'b00,
      UNL_KEY1 = 2'b01,
      UNL_ARMED = 2'b10
   } pim_unlock_t;

endpackage

// ---- rtl/pim_route_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface pim_route_if;
   import pim_pkg::*;
   logic [NUM_PINS-1:0] pins;
   logic [SEL_W-1:0] sel;
   logic level;
   modport mux (input pins, input sel, output level);
   modport ctrl (output pins, output sel, input level);
endinterface
`default_nettype wire

// ---- rtl/pim_pin_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module pim_pin_mux
   import pim_pkg::*;
(
   pim_route_if.mux rt
);
   always_comb begin
      if (rt.sel < SEL_W'(NUM_PINS)) begin
         rt.level = rt.pins[rt.sel[PIN_IDX_W-1:0]];
      end else begin
         rt.level = OUT_OF_TABLE_LEVEL;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pim_input_remap.sv ----
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pim_input_remap
   import pim_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [NUM_PINS-1:0] remappable_pin,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic capture4_pin_sel_in,
   output logic timer4_clock_pin_sel_in,
   output logic capture5_pin_sel_in,
   output logic timer5_clock_pin_sel_in,
   output logic capture6_pin_sel_in,
   output logic timer6_clock_pin_sel_in,
   output logic capture7_pin_sel_in,
   output logic timer7_clock_pin_sel_in,
   output logic capture8_pin_sel_in,
   output logic timer8_clock_pin_sel_in,
   output logic fault_b_pin_sel_in,
   output logic fault_a_pin_sel_in,
   output logic pwm_in9_pin_sel_in,
   output logic pwm_in8_pin_sel_in,
   output logic pwm_in11_pin_sel_in,
   output logic pwm_in10_pin_sel_in,
   output logic encoder1_phase_b_pin_sel_in,
   output logic encoder1_phase_a_pin_sel_in,
   output logic remap_lock_bit
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PINS-1:0] sync1;
      logic [NUM_PINS-1:0] sync2;
      logic [NUM_ROUTE-1:0][ROUTE_W-1:0] route;
      logic lock;
      pim_unlock_t unlock;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [NUM_OUT-1:0] periph;
   } pim_state_t;

   pim_state_t r;
   pim_state_t next_r;
   logic [NUM_OUT-1:0] mux_level;
   logic wr_fire;
   logic rd_fire;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;
   logic addr_ok_wr;
   logic addr_ok_rd;

   // ----------------------------------------------------------------
   // Selector muxes
   // ----------------------------------------------------------------
   pim_route_if route_bus[NUM_OUT] ();

   // Even outputs take the high field, odd outputs the low one
   genvar g;
   generate
      for (g = 0; g < NUM_ROUTE; g++) begin : g_route
         assign route_bus[2*g].sel = r.route[g][HI_LSB +: SEL_W];
         assign route_bus[2*g+1].sel = r.route[g][LO_LSB +: SEL_W];
      end
      for (g = 0; g < NUM_OUT; g++) begin : g_mux
         assign route_bus[g].pins = r.sync2;
         assign mux_level[g] = route_bus[g].level;
         pim_pin_mux u_mux (
            .rt(route_bus[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   assign wr_idx = r.aw_addr[ADDR_W-1:2];
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];
   assign addr_ok_wr = r.aw_addr[1:0] == 2'h0;
   assign addr_ok_rd = s_axi_araddr[1:0] == 2'h0;
   assign wr_fire = r.aw_held && r.w_held && !r.bvalid;
   assign rd_fire = s_axi_arvalid && r.arready;

   always_comb begin
      next_r = r;
      // Two stages before any mux sees a pin
      next_r.sync1 = remappable_pin;
      next_r.sync2 = r.sync1;
      // Registered so every peripheral input comes from a flop
      next_r.periph = mux_level;

      if (s_axi_awvalid && r.awready) begin
         next_r.aw_held = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.w_held = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end

      if (wr_fire) begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_OKAY;
         // Any write other than the key sequence disarms the unlock
         next_r.unlock = UNL_IDLE;
         if (!addr_ok_wr) begin
            next_r.bresp = RESP_SLVERR;
         end else if (wr_idx < IDX_W'(NUM_ROUTE)) begin
            if (!r.lock) begin
               if (r.w_strb[STRB_HI]) begin
                  next_r.route[wr_idx[3:0]][HI_LSB +: SEL_W] = r.w_data[HI_LSB +: SEL_W];
               end
               if (r.w_strb[STRB_LO]) begin
                  next_r.route[wr_idx[3:0]][LO_LSB +: SEL_W] = r.w_data[LO_LSB +: SEL_W];
               end
            end
         end else if (wr_idx == IDX_LOCK) begin
            if (r.unlock == UNL_ARMED && r.w_strb[STRB_HI]) begin
               next_r.lock = r.w_data[LOCK_BIT];
            end
         end else if (wr_idx == IDX_KEY) begin
            if (r.w_strb[STRB_LO]) begin
               unique case (r.unlock)
                  UNL_IDLE: begin
                     if (r.w_data[LO_LSB +: SEL_W] == KEY_FIRST) begin
                        next_r.unlock = UNL_KEY1;
                     end
                  end
                  UNL_KEY1: begin
                     if (r.w_data[LO_LSB +: SEL_W] == KEY_SECOND) begin
                        next_r.unlock = UNL_ARMED;
                     end
                  end
                  UNL_ARMED: begin
                     if (r.w_data[LO_LSB +: SEL_W] == KEY_FIRST) begin
                        next_r.unlock = UNL_KEY1;
                     end
                  end
                  default: begin
                     next_r.unlock = UNL_IDLE;
                  end
               endcase
            end
         end else begin
            next_r.bresp = RESP_SLVERR;
         end
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      // One write in flight: hold both channels until the answer is taken
      next_r.awready = !next_r.aw_held && !next_r.bvalid;
      next_r.wready = !next_r.w_held && !next_r.bvalid;

      if (rd_fire) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = RESP_OKAY;
         next_r.rdata = '0;
         if (!addr_ok_rd) begin
            next_r.rresp = RESP_SLVERR;
         end else if (rd_idx < IDX_W'(NUM_ROUTE)) begin
            next_r.rdata[ROUTE_W-1:0] = r.route[rd_idx[3:0]];
         end else if (rd_idx == IDX_LOCK) begin
            next_r.rdata[LOCK_BIT] = r.lock;
         end else if (rd_idx == IDX_KEY) begin
            next_r.rdata[1:0] = r.unlock;
         end else begin
            next_r.rresp = RESP_SLVERR;
         end
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
      next_r.arready = !next_r.rvalid;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign remap_lock_bit = r.lock;
   assign capture4_pin_sel_in = r.periph[0];
   assign timer4_clock_pin_sel_in = r.periph[1];
   assign capture5_pin_sel_in = r.periph[2];
   assign timer5_clock_pin_sel_in = r.periph[3];
   assign capture6_pin_sel_in = r.periph[4];
   assign timer6_clock_pin_sel_in = r.periph[5];
   assign capture7_pin_sel_in = r.periph[6];
   assign timer7_clock_pin_sel_in = r.periph[7];
   assign capture8_pin_sel_in = r.periph[8];
   assign timer8_clock_pin_sel_in = r.periph[9];
   assign fault_b_pin_sel_in = r.periph[10];
   assign fault_a_pin_sel_in = r.periph[11];
   assign pwm_in9_pin_sel_in = r.periph[12];
   assign pwm_in8_pin_sel_in = r.periph[13];
   assign pwm_in11_pin_sel_in = r.periph[14];
   assign pwm_in10_pin_sel_in = r.periph[15];
   assign encoder1_phase_b_pin_sel_in = r.periph[16];
   assign encoder1_phase_a_pin_sel_in = r.periph[17];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   AST_ROUTE_WRITE: assert property (
      wr_fire && !r.lock && addr_ok_wr && wr_idx == IDX_ROUTE_FIRST && r.w_strb[1:0] == 2'h3
      |=> r.route[0] == $past(r.w_data[ROUTE_W-1:0]))
      else $error("route write not stored");

   AST_LOCK_BLOCKS: assert property (
      wr_fire && r.lock && wr_idx < IDX_W'(NUM_ROUTE) |=> $stable(r.route))
      else $error("route changed while locked");

   AST_LOCK_NEEDS_KEY: assert property (
      $changed(r.lock) |-> $past(wr_fire && wr_idx == IDX_LOCK && r.unlock == UNL_ARMED))
      else $error("lock changed without unlock sequence");

   AST_CAP4_ROUTE: assert property (
      r.route[0][HI_LSB +: SEL_W] < SEL_W'(NUM_PINS) && $stable(r.route[0])
      |=> capture4_pin_sel_in == $past(r.sync2[r.route[0][HI_LSB +: PIN_IDX_W]]))
      else $error("capture 4 not fed by selected pin");

   AST_ENC_A_ROUTE: assert property (
      r.route[8][LO_LSB +: SEL_W] < SEL_W'(NUM_PINS) && $stable(r.route[8])
      |=> encoder1_phase_a_pin_sel_in == $past(r.sync2[r.route[8][LO_LSB +: PIN_IDX_W]]))
      else $error("encoder phase A not fed by selected pin");

   AST_PWM8_ROUTE: assert property (
      r.route[6][LO_LSB +: SEL_W] < SEL_W'(NUM_PINS) && $stable(r.route[6])
      |=> pwm_in8_pin_sel_in == $past(r.sync2[r.route[6][LO_LSB +: PIN_IDX_W]]))
      else $error("PWM input 8 not fed by selected pin");

   AST_OUT_OF_TABLE: assert property (
      r.route[5][LO_LSB +: SEL_W] >= SEL_W'(NUM_PINS) ##1 r.route[5][LO_LSB +: SEL_W] >= SEL_W'(NUM_PINS)
      |-> fault_a_pin_sel_in == OUT_OF_TABLE_LEVEL)
      else $error("out-of-table code not constant");

   // Release lands on an edge while the flops still see reset, so skip two edges after it
   AST_SYNC_DEPTH: assert property (
      $past(arst_n, 2) |-> r.sync2 == $past(remappable_pin, 2))
      else $error("pin synchroniser depth wrong");

   AST_READBACK: assert property (
      rd_fire && addr_ok_rd && rd_idx < IDX_W'(NUM_ROUTE)
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(r.route[rd_idx[3:0]])})
      else $error("route readback wrong");

   AST_BRESP_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

endmodule
`default_nettype wire

// ---- verification/pim_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pim_pin_model
   import pim_pkg::*;
(
   input wire logic core_clk,
   input wire logic load,
   input wire logic [NUM_PINS-1:0] levels,
   output logic [NUM_PINS-1:0] remappable_pin
);
   // Pins change right after an edge, away from the sync flops' sampling
   always_ff @(posedge core_clk) begin
      if (load) begin
         remappable_pin <= levels;
      end
   end
endmodule
`default_nettype wire

// ---- verification/pim_input_remap_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pim_input_remap_tb_top
   import pim_pkg::*;
;
   logic core_clk, arst_n, ld, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, lock;
   logic [NUM_PINS-1:0] lv, pins, pexp;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   wire [17:0] o;
   logic [15:0] mir [0:8];
   int err_count, n_compared;
   localparam logic [7:0] A_LOCK = {IDX_LOCK, 2'b00};
   localparam logic [7:0] A_KEY = {IDX_KEY, 2'b00};

   pim_pin_model pim_pin_model_inst (.core_clk(core_clk), .load(ld), .levels(lv), .remappable_pin(pins));
   pim_input_remap pim_input_remap_inst (.core_clk(core_clk), .arst_n(arst_n), .remappable_pin(pins),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture4_pin_sel_in(o[17]), .timer4_clock_pin_sel_in(o[16]), .capture5_pin_sel_in(o[15]),
      .timer5_clock_pin_sel_in(o[14]), .capture6_pin_sel_in(o[13]), .timer6_clock_pin_sel_in(o[12]),
      .capture7_pin_sel_in(o[11]), .timer7_clock_pin_sel_in(o[10]), .capture8_pin_sel_in(o[9]),
      .timer8_clock_pin_sel_in(o[8]), .fault_b_pin_sel_in(o[7]), .fault_a_pin_sel_in(o[6]),
      .pwm_in9_pin_sel_in(o[5]), .pwm_in8_pin_sel_in(o[4]), .pwm_in11_pin_sel_in(o[3]),
      .pwm_in10_pin_sel_in(o[2]), .encoder1_phase_b_pin_sel_in(o[1]), .encoder1_phase_a_pin_sel_in(o[0]),
      .remap_lock_bit(lock));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      chk_data({30'h0, g}, {30'h0, e});
   endtask

   task automatic chk_lvl(input logic g, input logic e);
      chk_data({31'h0, g}, {31'h0, e});
   endtask

   task automatic timed_out;
      err_count++;
      $display("wait bound used up at %0t", $time);
      complete_run();
   endtask

   function automatic logic exp_lvl(input logic [NUM_PINS-1:0] p, input logic [SEL_W-1:0] s);
      return (s < NUM_PINS) ? p[s[PIN_IDX_W-1:0]] : OUT_OF_TABLE_LEVEL;
   endfunction

   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
      int n;
      logic aw, w, got;
      n = 0;
      aw = 1;
      w = 1;
      got = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got && n < 40) begin
         @(posedge core_clk);
         n++;
         if (!aw && !w && bvalid === 1'b1) begin
            got = 1;
            chk_resp(bresp, e);
         end
         if (aw && awready === 1'b1) begin
            aw = 0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
      if (!got) timed_out();
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
      int n;
      logic ar, got;
      n = 0;
      ar = 1;
      got = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got && n < 40) begin
         @(posedge core_clk);
         n++;
         if (!ar && rvalid === 1'b1) begin
            got = 1;
            chk_resp(rresp, e);
            chk_data(rdata, ed);
         end
         if (ar && arready === 1'b1) begin
            ar = 0;
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
      if (!got) timed_out();
   endtask

   // Seven edges cover model load, two sync stages and the output flop
   task automatic set_pins(input logic [NUM_PINS-1:0] v);
      @(posedge core_clk);
      lv <= v;
      ld <= 1'b1;
      pexp = v;
      @(posedge core_clk);
      ld <= 1'b0;
      repeat (5) @(posedge core_clk);
   endtask

   task automatic chk_outs;
      @(posedge core_clk);
      for (int k = 0; k < NUM_ROUTE; k++) begin
         chk_lvl(o[17-2*k], exp_lvl(pexp, mir[k][15:8]));
         chk_lvl(o[16-2*k], exp_lvl(pexp, mir[k][7:0]));
      end
   endtask

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      logic [15:0] v;
      arst_n = 1'b0;
      ld = 1'b1;
      lv = '0;
      pexp = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      err_count = 0;
      n_compared = 0;
      v = 16'($urandom(32'hA86B88A6));
      for (int k = 0; k < NUM_ROUTE; k++) mir[k] = ROUTE_RESET;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int k = 0; k < NUM_ROUTE; k++) rchk(8'(4*k), 32'h0, RESP_OKAY);
      rchk(A_LOCK, 32'h0, RESP_OKAY);
      chk_outs();
      $display("test reset_values finished");
      for (int rnd = 0; rnd < 4; rnd++) begin
         set_pins({$urandom, $urandom});
         for (int k = 0; k < NUM_ROUTE; k++) begin
            // Last round pushes both codes past the pin table
            v = (rnd == 3) ? 16'($urandom) | 16'h4040 : 16'($urandom) & 16'h3F3F;
            wchk(8'(4*k), {16'($urandom), v}, 4'hF, RESP_OKAY);
            mir[k] = v;
            rchk(8'(4*k), {16'h0, v}, RESP_OKAY);
         end
         chk_outs();
         set_pins(~pexp);
         chk_outs();
      end
      wchk(8'h00, 32'h0000_2A15, 4'h1, RESP_OKAY);
      mir[0][7:0] = 8'h15;
      rchk(8'h00, {16'h0, mir[0]}, RESP_OKAY);
      $display("test routing finished");
      rchk(8'h2C, 32'h0, RESP_SLVERR);
      rchk(8'h06, 32'h0, RESP_SLVERR);
      wchk(8'h30, 32'h0000_1111, 4'hF, RESP_SLVERR);
      rchk(8'h04, {16'h0, mir[1]}, RESP_OKAY);
      $display("test bad_address finished");
      // Key pair first, as software must before touching the lock
      wchk(A_KEY, {24'h0, KEY_FIRST}, 4'h1, RESP_OKAY);
      rchk(A_KEY, {30'h0, UNL_KEY1}, RESP_OKAY);
      wchk(A_KEY, {24'h0, KEY_SECOND}, 4'h1, RESP_OKAY);
      rchk(A_KEY, {30'h0, UNL_ARMED}, RESP_OKAY);
      wchk(A_LOCK, 32'h0000_0800, 4'h2, RESP_OKAY);
      @(posedge core_clk);
      chk_lvl(lock, 1'b1);
      rchk(A_LOCK, 32'h0000_0800, RESP_OKAY);
      for (int k = 0; k < NUM_ROUTE; k++) begin
         wchk(8'(4*k), 32'($urandom), 4'hF, RESP_OKAY);
         rchk(8'(4*k), {16'h0, mir[k]}, RESP_OKAY);
      end
      chk_outs();
      wchk(A_KEY, {24'h0, KEY_FIRST}, 4'h1, RESP_OKAY);
      wchk(A_KEY, {24'h0, KEY_SECOND}, 4'h1, RESP_OKAY);
      wchk(A_LOCK, 32'h0, 4'h2, RESP_OKAY);
      @(posedge core_clk);
      chk_lvl(lock, 1'b0);
      wchk(A_LOCK, 32'h0000_0800, 4'h2, RESP_OKAY);
      @(posedge core_clk);
      chk_lvl(lock, 1'b0);
      wchk(8'h20, 32'h0000_3F00, 4'hF, RESP_OKAY);
      mir[8] = 16'h3F00;
      rchk(8'h20, 32'h0000_3F00, RESP_OKAY);
      chk_outs();
      $display("test lock finished");
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      rchk(8'h20, 32'h0, RESP_OKAY);
      // Reset selectors all pick pin 0 again
      for (int k = 0; k < NUM_ROUTE; k++) mir[k] = ROUTE_RESET;
      chk_outs();
      $display("test second_reset finished");
      complete_run();
   end
endmodule
`default_nettype wire
